// >>> inc/dcb_pkg.sv
// Purpose: shared types and constants of the command and bank logic
// Assumes: four banks, twelve address pins, x4 column layout
// Notes:   timer values count rising edges of the memory clock
package dcb_pkg;
    // Bank life cycle, Gray coded along idle, active, closing
    typedef enum logic [1:0]
    {
        BK_IDLE    = 2'b00,
        BK_ACTIVE  = 2'b01,
        BK_CLOSING = 2'b11
    } dcb_bank_st_t;

    // Command code is {ras, cas, we} with chip select low
    typedef enum logic [2:0]
    {
        CMD_MODE    = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_CLOSE   = 3'h2,
        CMD_OPEN    = 3'h3,
        CMD_WRITE   = 3'h4,
        CMD_READ    = 3'h5,
        CMD_STOP    = 3'h6,
        CMD_NOP     = 3'h7
    } dcb_cmd_t;

    typedef struct packed
    {
        logic        csN;
        logic        rasN;
        logic        casN;
        logic        weN;
        logic        cke;
        logic [1:0]  ba;
        logic [11:0] addr;
        logic        dm;
        logic [7:0]  dq;
    } dcb_pin_t;

    typedef struct packed
    {
        logic [7:0] rowOpen;
        logic [7:0] rowClose;
        logic [7:0] openToCol;
        logic [7:0] modeLoad;
    } dcb_timing_t;

    typedef struct packed
    {
        dcb_bank_st_t st;
        logic [11:0]  row;
        logic [7:0]   age;
        logic         autoPend;
    } dcb_bank_t;

    typedef struct packed
    {
        logic        valid;
        dcb_cmd_t    cmd;
        logic [1:0]  bank;
        logic [11:0] addr;
        logic        autoClose;
    } dcb_event_t;

    // Register offsets
    localparam logic [7:0] OFS_TIMING  = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_MODE    = 8'h08;
    localparam logic [7:0] OFS_REFRESH = 8'h0C;
    // Timer values after reset
    localparam dcb_timing_t TIMING_RST = 32'h0606_0302;
    // Address and field positions
    localparam int A_AUTO = 10;
    localparam int A_COLHI = 11;
    localparam int EXT_DLL = 0;
    localparam int EXT_DRIVE = 1;
    localparam int EXT_ISO = 2;
    localparam logic [1:0] BA_BASE = 2'h0;
    localparam logic [1:0] BA_EXT  = 2'h1;
    // Burst length codes and their length in clock cycles
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BLC_2 = 3'h1;
    localparam logic [2:0] BLC_4 = 3'h2;
    localparam logic [2:0] BLC_8 = 3'h4;
endpackage : dcb_pkg

// >>> core/dcb_cmd_bank.sv
// Purpose: command decoder and per-bank row state of a four-bank DRAM
// Assumes: memory clock is a pin sampled by clock; commands held
//          steady across each memory clock rising edge
// Notes:   all state lives in one struct, one comb and one ff process
//
// Functional notes
// [RULE_01] Chip select high ignored; low decodes ras/cas/we into eight commands.
// [RULE_02] Controller holds cke high except when entering self refresh.
// [RULE_03] Mode load writes address into base (bank 0) or extended (bank 1).
// [RULE_04] Row open takes bank and row, marks that bank's row open.
// [RULE_05] Column from A9..A0 plus A11; A10 requests auto-close for one access.
// [RULE_06] Close with A10 low closes one bank, A10 high closes all.
// [RULE_07] Refresh with cke high refreshes once, with cke low enters self refresh.
// [RULE_08] Refresh row and bank come from an internal counter.
// [RULE_09] Controller uses burst stop only on reads without auto-close.
// [RULE_10] Write elements with mask low are stored, mask high discarded.
// [RULE_11] Deselect and no-op start nothing and leave running work alone.
// [RULE_12] Controller loads modes only when idle, then waits mode-load delay.
// [RULE_13] Controller closes a row before opening another in that bank.
// [RULE_14] Auto-close closes the row at burst end, else row stays open.
// [RULE_15] Closed bank goes idle after row-close time; needs open before access.
// [RULE_16] Close to a bank idle or already closing acts as no-op.
// [RULE_17] Auto-close starts at the earliest legal explicit close point.
// [RULE_18] Controller waits row-close time after auto-close before that bank.
// [RULE_19] Early auto-close read holds close until burst done and open time met.
// [RULE_20] Any read accepted once the open-to-column delay has passed.
// [RULE_21] Extended mode holds DLL enable A0, drive strength A1, isolation A2.
// [RULE_22] Controller waits 200 cycles after DLL enable before reading.
// [RULE_23] Timing values are counters with software-set terminal counts.
`timescale 1ns/1ns
module dcb_cmd_bank
(
    // Clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // Memory pins from the controller
    input  wire logic               memClk,
    input  wire dcb_pkg::dcb_pin_t  pinIn,
    // Register port
    input  wire logic [7:0]         regAddr,
    input  wire logic [31:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic [31:0]             regRdata,
    // Decoded commands and bank view
    output dcb_pkg::dcb_event_t     cmdEvent,
    output logic [3:0]              bankOpen,
    output logic                    selfRefresh,
    output logic                    refreshPulse,
    output logic [13:0]             refreshAddr,
    // Array write port
    output logic                    memWrEn,
    output logic [7:0]              memWrData,
    // Module isolation open-drain pin
    output logic                    isoOut,
    output logic                    isoOe,
    // Extended mode fields
    output logic                    dllCtrl,
    output logic                    driveSel
);
    typedef struct packed
    {
        dcb_pkg::dcb_pin_t        pinS1;
        dcb_pkg::dcb_pin_t        pinS2;
        dcb_pkg::dcb_pin_t        pinPrev;
        logic [2:0]               ckS;
        dcb_pkg::dcb_bank_t [3:0] bank;
        logic [2:0]               burstCnt;
        logic [1:0]               burstBank;
        logic                     burstWrite;
        logic                     burstAuto;
        logic [11:0]              baseMode;
        logic [11:0]              extMode;
        logic [7:0]               mrdCnt;
        logic                     selfRef;
        logic [13:0]              refCnt;
        logic                     refPulse;
        dcb_pkg::dcb_timing_t     timing;
        logic                     memWrEn;
        logic [7:0]               memWrData;
        logic                     isoOe;
        dcb_pkg::dcb_event_t      evt;
        logic [31:0]              rdata;
    } dcb_state_t;

    dcb_state_t        s_r;
    dcb_state_t        s_nxt;
    logic              ckRise;
    logic              ckEdge;
    dcb_pkg::dcb_cmd_t cmdCode;
    logic              cmdLive;
    logic [2:0]        blCycles;
    logic [3:0]        colReady;
    logic [3:0]        closing;

    // Edge finding on the sampled memory clock, command seen before edge
    assign ckRise  = s_r.ckS[1] & ~s_r.ckS[2];
    assign ckEdge  = s_r.ckS[1] ^ s_r.ckS[2];
    assign cmdCode = dcb_pkg::dcb_cmd_t'({s_r.pinPrev.rasN,
                                          s_r.pinPrev.casN,
                                          s_r.pinPrev.weN});
    assign cmdLive = ckRise & ~s_r.pinPrev.csN & ~s_r.selfRef; // [RULE_01]

    // Burst length in memory clock cycles from the base mode
    always_comb
    begin
        case (s_r.baseMode[2:0])
            dcb_pkg::BL_4: blCycles = dcb_pkg::BLC_4;
            dcb_pkg::BL_8: blCycles = dcb_pkg::BLC_8;
            default:       blCycles = dcb_pkg::BLC_2;
        endcase
    end

    // Per-bank status views
    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            colReady[b] = (s_r.bank[b].st == dcb_pkg::BK_ACTIVE) &&
                (s_r.bank[b].age >= s_r.timing.openToCol); // [RULE_20]
            closing[b]  = (s_r.bank[b].st == dcb_pkg::BK_CLOSING);
        end
    end

    // Whole next state
    always_comb
    begin
        logic endNow;
        logic pend;
        s_nxt          = s_r;
        endNow         = 1'b0;
        pend           = 1'b0;
        // Two-stage sampling of every pin, memory clock included
        s_nxt.pinS1    = pinIn;
        s_nxt.pinS2    = s_r.pinS1;
        s_nxt.pinPrev  = s_r.pinS2;
        s_nxt.ckS      = {s_r.ckS[1:0], memClk};
        s_nxt.evt.valid = 1'b0;
        s_nxt.refPulse = 1'b0;
        s_nxt.memWrEn  = 1'b0;
        // Write data taken on both memory clock edges
        if (ckEdge && s_r.burstCnt != 3'h0 && s_r.burstWrite)
        begin
            s_nxt.memWrEn   = ~s_r.pinPrev.dm; // [RULE_10]
            s_nxt.memWrData = s_r.pinPrev.dq;
        end
        // Self refresh ends once cke is seen high again
        if (s_r.selfRef && s_r.pinPrev.cke)
            s_nxt.selfRef = 1'b0;
        if (ckRise)
        begin
            // Burst runs down regardless of idle commands
            if (s_r.burstCnt != 3'h0)
            begin
                s_nxt.burstCnt = s_r.burstCnt - 3'h1; // [RULE_11]
                endNow = (s_r.burstCnt == 3'h1) && s_r.burstAuto;
            end
            if (s_r.mrdCnt != 8'h00)
                s_nxt.mrdCnt = s_r.mrdCnt - 8'h01; // [RULE_23]
            // Bank timers; auto-close fires as soon as open time is met
            for (int b = 0; b < 4; b++)
            begin
                pend = s_r.bank[b].autoPend ||
                       (endNow && s_r.burstBank == 2'(b));
                case (s_r.bank[b].st)
                    dcb_pkg::BK_ACTIVE:
                    begin
                        if (s_r.bank[b].age != 8'hFF)
                            s_nxt.bank[b].age = s_r.bank[b].age + 8'h01;
                        s_nxt.bank[b].autoPend = pend;
                        // Age lags this rise by one, so count it too
                        if (pend && {1'b0, s_r.bank[b].age} + 9'h001 >=
                            {1'b0, s_r.timing.rowOpen}) // [RULE_17] [RULE_19]
                        begin
                            s_nxt.bank[b].st       = dcb_pkg::BK_CLOSING;
                            s_nxt.bank[b].age      = 8'h00; // [RULE_14]
                            s_nxt.bank[b].autoPend = 1'b0;
                        end
                    end
                    dcb_pkg::BK_CLOSING:
                    begin
                        s_nxt.bank[b].age = s_r.bank[b].age + 8'h01;
                        if (s_r.bank[b].age + 8'h01 >= s_r.timing.rowClose)
                            s_nxt.bank[b].st = dcb_pkg::BK_IDLE; // [RULE_15]
                    end
                    default:
                        s_nxt.bank[b].age = 8'h00;
                endcase
            end
        end
        // Command decode; deselect and no-op fall through untouched
        if (cmdLive)
        begin
            s_nxt.evt = '{valid: 1'b1, cmd: cmdCode,
                          bank: s_r.pinPrev.ba, addr: s_r.pinPrev.addr,
                          autoClose: 1'b0};
            case (cmdCode)
                dcb_pkg::CMD_OPEN:
                begin
                    if (s_r.bank[s_r.pinPrev.ba].st == dcb_pkg::BK_IDLE)
                    begin
                        s_nxt.bank[s_r.pinPrev.ba] = '{ // [RULE_04]
                            st: dcb_pkg::BK_ACTIVE,
                            row: s_r.pinPrev.addr,
                            age: 8'h00, autoPend: 1'b0};
                    end
                end
                dcb_pkg::CMD_READ,
                dcb_pkg::CMD_WRITE:
                begin
                    // Column is A9..A0 with A11 on top; A10 is auto-close
                    s_nxt.evt.addr = {1'b0, s_r.pinPrev.addr[dcb_pkg::A_COLHI],
                                      s_r.pinPrev.addr[9:0]}; // [RULE_05]
                    s_nxt.evt.autoClose =
                        s_r.pinPrev.addr[dcb_pkg::A_AUTO];
                    if (s_r.bank[s_r.pinPrev.ba].st == dcb_pkg::BK_ACTIVE)
                    begin
                        s_nxt.burstCnt   = blCycles;
                        s_nxt.burstBank  = s_r.pinPrev.ba;
                        s_nxt.burstWrite = (cmdCode == dcb_pkg::CMD_WRITE);
                        s_nxt.burstAuto  =
                            s_r.pinPrev.addr[dcb_pkg::A_AUTO]; // [RULE_05]
                    end
                end
                dcb_pkg::CMD_STOP:
                begin
                    // Only reads may be cut; a write burst keeps going
                    if (!s_r.burstWrite)
                        s_nxt.burstCnt = 3'h0; // [RULE_09]
                end
                dcb_pkg::CMD_CLOSE:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if ((s_r.pinPrev.addr[dcb_pkg::A_AUTO] ||
                             s_r.pinPrev.ba == 2'(b)) && // [RULE_06]
                            s_r.bank[b].st == dcb_pkg::BK_ACTIVE) // [RULE_16]
                        begin
                            s_nxt.bank[b].st       = dcb_pkg::BK_CLOSING;
                            s_nxt.bank[b].age      = 8'h00;
                            s_nxt.bank[b].autoPend = 1'b0;
                        end
                    end
                end
                dcb_pkg::CMD_REFRESH:
                begin
                    // Address pins play no part; the counter picks the row
                    s_nxt.evt.addr = 12'h000;
                    if (s_r.pinPrev.cke)
                    begin
                        s_nxt.refPulse = 1'b1; // [RULE_07]
                        s_nxt.refCnt   = s_r.refCnt + 14'h0001; // [RULE_08]
                    end
                    else
                        s_nxt.selfRef = 1'b1; // [RULE_07]
                end
                dcb_pkg::CMD_MODE:
                begin
                    if (s_r.pinPrev.ba == dcb_pkg::BA_BASE)
                        s_nxt.baseMode = s_r.pinPrev.addr; // [RULE_03]
                    else if (s_r.pinPrev.ba == dcb_pkg::BA_EXT)
                        s_nxt.extMode = s_r.pinPrev.addr; // [RULE_21]
                    s_nxt.mrdCnt = s_r.timing.modeLoad; // [RULE_23]
                end
                default: s_nxt.evt.valid = 1'b0; // [RULE_11]
            endcase
        end
        // Isolation pin pulled low during read bursts when enabled
        s_nxt.isoOe = s_r.extMode[dcb_pkg::EXT_ISO] &&
                      s_nxt.burstCnt != 3'h0 && !s_nxt.burstWrite;
        // Register port; read data stands one cycle only
        if (regWr && regAddr == dcb_pkg::OFS_TIMING)
            s_nxt.timing = regWdata; // [RULE_23]
        s_nxt.rdata = 32'h0000_0000;
        if (regRd)
        begin
            case (regAddr)
                dcb_pkg::OFS_TIMING: s_nxt.rdata = s_r.timing;
                dcb_pkg::OFS_STATUS:
                    s_nxt.rdata = {18'h00000, (s_r.mrdCnt != 8'h00),
                                   s_r.selfRef, colReady, closing,
                                   (colReady | {s_r.bank[3].st == dcb_pkg::BK_ACTIVE,
                                    s_r.bank[2].st == dcb_pkg::BK_ACTIVE,
                                    s_r.bank[1].st == dcb_pkg::BK_ACTIVE,
                                    s_r.bank[0].st == dcb_pkg::BK_ACTIVE})};
                dcb_pkg::OFS_MODE:
                    s_nxt.rdata = {4'h0, s_r.extMode, 4'h0, s_r.baseMode};
                dcb_pkg::OFS_REFRESH: s_nxt.rdata = {18'h00000, s_r.refCnt};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register; pins start deselected so reset is quiet
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_r             <= '0;
            s_r.pinS1.csN   <= 1'b1;
            s_r.pinS2.csN   <= 1'b1;
            s_r.pinPrev.csN <= 1'b1;
            s_r.timing      <= dcb_pkg::TIMING_RST;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs from the state register; isoOut tied low, bankOpen decoded from bank states
    assign regRdata     = s_r.rdata;
    assign cmdEvent     = s_r.evt;
    assign selfRefresh  = s_r.selfRef;
    assign refreshPulse = s_r.refPulse;
    assign refreshAddr  = s_r.refCnt;
    assign memWrEn      = s_r.memWrEn;
    assign memWrData    = s_r.memWrData;
    assign isoOut       = 1'b0;
    assign isoOe        = s_r.isoOe;
    assign dllCtrl      = s_r.extMode[dcb_pkg::EXT_DLL]; // [RULE_21]
    assign driveSel     = s_r.extMode[dcb_pkg::EXT_DRIVE];
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            bankOpen[b] = (s_r.bank[b].st == dcb_pkg::BK_ACTIVE);
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_cs_ignore: assert property (ckRise && s_r.pinPrev.csN // [RULE_01]
        |=> !s_r.evt.valid) else $error("deselected command decoded");
    a_mode_base: assert property (cmdLive && cmdCode == dcb_pkg::CMD_MODE // [RULE_03]
        && s_r.pinPrev.ba == dcb_pkg::BA_BASE
        |=> s_r.baseMode == $past(s_r.pinPrev.addr))
        else $error("base mode not loaded");
    a_row_open: assert property (cmdLive && cmdCode == dcb_pkg::CMD_OPEN // [RULE_04]
        && s_r.bank[0].st == dcb_pkg::BK_IDLE && s_r.pinPrev.ba == 2'h0
        |=> s_r.bank[0].st == dcb_pkg::BK_ACTIVE
        && s_r.bank[0].row == $past(s_r.pinPrev.addr))
        else $error("row open not recorded");
    a_close_all: assert property (cmdLive && cmdCode == dcb_pkg::CMD_CLOSE // [RULE_06]
        && s_r.pinPrev.addr[dcb_pkg::A_AUTO] |=> bankOpen == 4'h0)
        else $error("close all left a row open");
    a_refresh_cnt: assert property (cmdLive && cmdCode == dcb_pkg::CMD_REFRESH // [RULE_08]
        && s_r.pinPrev.cke |=> refreshPulse
        && s_r.refCnt == $past(s_r.refCnt) + 14'h0001)
        else $error("refresh counter not stepped");
    a_self_entry: assert property (cmdLive && cmdCode == dcb_pkg::CMD_REFRESH // [RULE_07]
        && !s_r.pinPrev.cke |=> selfRefresh && !refreshPulse)
        else $error("self refresh not entered");
    a_nop_burst: assert property (ckRise && cmdCode == dcb_pkg::CMD_NOP // [RULE_11]
        && s_r.burstCnt != 3'h0
        |=> s_r.burstCnt == $past(s_r.burstCnt) - 3'h1)
        else $error("no-op disturbed a burst");
    a_mask_write: assert property (ckEdge && s_r.burstWrite // [RULE_10]
        && s_r.burstCnt != 3'h0
        |=> memWrEn == !$past(s_r.pinPrev.dm))
        else $error("write mask not honoured");
    a_auto_hold: assert property (s_r.bank[0].autoPend // [RULE_19]
        && {1'b0, s_r.bank[0].age} + 9'h001 < {1'b0, s_r.timing.rowOpen}
        && !cmdLive
        |=> s_r.bank[0].st != dcb_pkg::BK_CLOSING)
        else $error("auto-close before open time");
    a_close_noop: assert property (cmdLive && cmdCode == dcb_pkg::CMD_CLOSE // [RULE_16]
        && s_r.bank[1].st == dcb_pkg::BK_IDLE
        |=> s_r.bank[1].st == dcb_pkg::BK_IDLE)
        else $error("close woke an idle bank");
    c_open: cover property (cmdLive && cmdCode == dcb_pkg::CMD_OPEN);
    c_auto_read: cover property (cmdLive && cmdCode == dcb_pkg::CMD_READ
        && s_r.pinPrev.addr[dcb_pkg::A_AUTO]);
    c_self_ref: cover property (selfRefresh);
    c_ext_load: cover property (cmdLive && cmdCode == dcb_pkg::CMD_MODE
        && s_r.pinPrev.ba == dcb_pkg::BA_EXT);
endmodule : dcb_cmd_bank

// >>> tb/dcb_ctrl_model.sv
// Purpose: memory controller model, clock, commands and write data
// Assumes: pins change at the clock fall, data a quarter period late
// Notes:   released lines show the inverse of their last value, except chip select, which goes high, and cke, which holds
`timescale 1ns/1ns
module dcb_ctrl_model
(
    // Memory pins
    output logic              memClk,
    output dcb_pkg::dcb_pin_t pins
);
    logic [8:0] wrQ[$];
    logic       wrGo = 1'b0;

    // Free running memory clock, pins start deselected with cke high
    initial
    begin
        memClk = 1'b0;
        pins = 28'h8800000;
        forever
        begin
            #63 memClk = 1'b1;
            #62 memClk = 1'b0;
        end
    end

    // Set up at a fall, held over the rise, released at the next fall
    task automatic issue(input dcb_pkg::dcb_pin_t p);
        @(negedge memClk);
        pins[27:9] <= p[27:9];
        @(posedge memClk);
        wrGo <= (wrQ.size() != 0);
        @(negedge memClk);
        pins[27:9] <= {1'b1, ~p[26:24], p.cke, ~p[22:9]};
    endtask : issue

    // Quarter period late, so each element brackets its sampling edge
    always @(memClk)
    begin
        #31;
        if (wrGo && wrQ.size() != 0)
            pins[8:0] = wrQ.pop_front();
        else
            pins[8:0] = ~pins[8:0];
        if (wrQ.size() == 0)
            wrGo = 1'b0;
    end
endmodule : dcb_ctrl_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench of the command and bank logic
// Assumes: controller model drives memory clock and pins
// Notes:   row open and close times drawn at random inside safe ranges
`timescale 1ns/1ns
module tb_top;
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    logic                memClk;
    dcb_pkg::dcb_pin_t   pinIn;
    logic [7:0]          regAddr = 8'h00;
    logic [31:0]         regWdata = 32'h0;
    logic                regWr = 1'b0;
    logic                regRd = 1'b0;
    logic [31:0]         regRdata;
    logic [31:0]         rd;
    dcb_pkg::dcb_event_t cmdEvent;
    dcb_pkg::dcb_event_t lastEv;
    logic [3:0]          bankOpen;
    logic [13:0]         refreshAddr;
    logic                selfRefresh, refreshPulse, memWrEn, dllCtrl, driveSel;
    logic [7:0]          memWrData;
    logic [7:0]          wrSeen[$];
    int                  badCount = 0;
    int                  checked = 0;
    int                  evCnt = 0;
    int                  refCnt = 0;

    // 100 MHz system clock
    always #5 clock = ~clock;

    dcb_ctrl_model ctl (.memClk, .pins(pinIn));
    dcb_cmd_bank dut
    (
        .clock, .rst_n, .memClk, .pinIn, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .cmdEvent, .bankOpen, .selfRefresh,
        .refreshPulse, .refreshAddr, .memWrEn, .memWrData, .isoOut(),
        .isoOe(), .dllCtrl, .driveSel
    );

    // Compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expv);
        checked++;
        if (seen !== expv)
        begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // One register write or read; read data stands one cycle only
    task automatic regAcc(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= w;
        regRd <= ~w;
        @(posedge clock);
        regWr <= 1'b0;
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : regAcc

    // One command through the model, then its decoded event
    task automatic cmd(input logic [2:0] c, input logic cs, input logic k,
                       input logic [1:0] b, input logic [11:0] a);
        int n;
        n = evCnt;
        ctl.issue({cs, c, k, b, a, 9'h000});
        repeat (2) @(posedge clock);
        if (cs)
            check("deselect event", evCnt - n, 0);
        else if (k && c != 3'h7)
            check("event", {29'(evCnt - n), lastEv.cmd}, {29'd1, c});
    endtask : cmd

    // Wait memory rises, then let the sync pipeline settle
    task automatic rises(input int n);
        repeat (n) @(posedge memClk);
        repeat (8) @(posedge clock);
    endtask : rises

    // Collect events, stored elements and refresh pulses
    always @(posedge clock)
    begin
        if (cmdEvent.valid === 1'b1)
        begin
            evCnt++;
            lastEv = cmdEvent;
        end
        if (memWrEn === 1'b1)
            wrSeen.push_back(memWrData);
        if (refreshPulse === 1'b1)
            refCnt++;
    end

    // Watchdog, well past the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        badCount++;
        summarize();
    end

    // Main sequence
    initial
    begin
        logic [7:0]  tOpen;
        logic [7:0]  tClose;
        logic [1:0]  b;
        logic [11:0] a;
        logic [11:0] ext;
        logic [8:0]  el;
        logic [7:0]  expQ[$];
        void'($urandom(32'h43691B5E));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        // Register port: reset value, read-only place, unmapped place
        regAcc(1'b0, dcb_pkg::OFS_TIMING, 32'h0);
        check("timing reset", rd, dcb_pkg::TIMING_RST);
        tOpen = 8'($urandom_range(8, 5));
        tClose = 8'($urandom_range(5, 2));
        regAcc(1'b1, dcb_pkg::OFS_TIMING, {tOpen, tClose, 16'h0302});
        regAcc(1'b1, dcb_pkg::OFS_MODE, $urandom());
        regAcc(1'b0, dcb_pkg::OFS_TIMING, 32'h0);
        check("timing", rd, {tOpen, tClose, 16'h0302});
        regAcc(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        // Mode loads while all banks idle: base, extended, reserved code
        a = {5'h00, 4'($urandom()), dcb_pkg::BL_4};
        ext = 12'($urandom_range(7, 0));
        cmd(3'h0, 1'b0, 1'b1, 2'h0, a);
        cmd(3'h0, 1'b0, 1'b1, 2'h1, ext);
        cmd(3'h0, 1'b0, 1'b1, 2'h2, 12'hFFF);
        regAcc(1'b0, dcb_pkg::OFS_MODE, 32'h0);
        check("mode", rd, {4'h0, ext, 4'h0, a});
        check("dll", dllCtrl, ext[0]);
        check("drive", driveSel, ext[1]);
        // Loop may just have been enabled; let it lock before reads
        rises(200);
        // Deselected open, then open and early auto-close read
        b = 2'($urandom());
        a = 12'($urandom());
        cmd(3'h3, 1'b1, 1'b1, b, a);
        check("deselect open", bankOpen, 4'h0);
        cmd(3'h3, 1'b0, 1'b1, b, a);
        check("open row", lastEv.addr, a);
        check("open bank", bankOpen, 4'h1 << b);
        a = 12'($urandom()) | 12'h400;
        cmd(3'h5, 1'b0, 1'b1, b, a);
        check("column", lastEv.addr, {1'b0, a[11], a[9:0]});
        check("auto flag", lastEv.autoClose, 1'b1);
        rises(tOpen - 4);
        check("lockout", bankOpen[b], 1'b1);
        rises(2);
        regAcc(1'b0, dcb_pkg::OFS_STATUS, 32'h0);
        check("auto close", rd[7:0], {4'h1 << b, 4'h0});
        rises(tClose + 1);
        regAcc(1'b0, dcb_pkg::OFS_STATUS, 32'h0);
        check("idle", rd[7:0], 8'h00);
        // Plain read keeps row; burst stop, nop, single and all close
        cmd(3'h3, 1'b0, 1'b1, 2'h0, a);
        cmd(3'h3, 1'b0, 1'b1, 2'h3, a);
        cmd(3'h5, 1'b0, 1'b1, 2'h0, 12'h000);
        cmd(3'h6, 1'b0, 1'b1, 2'h0, 12'h000);
        cmd(3'h7, 1'b0, 1'b1, 2'h0, 12'h000);
        rises(10);
        check("row kept", bankOpen, 4'h9);
        cmd(3'h2, 1'b0, 1'b1, 2'h3, 12'h000);
        check("close one", bankOpen, 4'h1);
        rises(tClose + 1);
        cmd(3'h2, 1'b0, 1'b1, 2'h3, 12'h000);
        regAcc(1'b0, dcb_pkg::OFS_STATUS, 32'h0);
        check("close idle", rd[7:4], 4'h0);
        cmd(3'h2, 1'b0, 1'b1, 2'h2, 12'h400);
        check("close all", bankOpen, 4'h0);
        rises(tClose + 1);
        // Write burst of four with random mask
        cmd(3'h3, 1'b0, 1'b1, b, a);
        wrSeen.delete();
        for (int i = 0; i < 4; i++)
        begin
            el = 9'($urandom());
            ctl.wrQ.push_back(el);
            if (!el[8])
                expQ.push_back(el[7:0]);
        end
        cmd(3'h4, 1'b0, 1'b1, b, 12'h000);
        rises(3);
        check("stored count", wrSeen.size(), expQ.size());
        foreach (expQ[i])
            check("stored data", wrSeen[i], expQ[i]);
        // Two auto refreshes, then self refresh entry and exit
        cmd(3'h1, 1'b0, 1'b1, 2'h0, 12'hFFF);
        cmd(3'h1, 1'b0, 1'b1, 2'h3, 12'h000);
        check("refresh pulses", refCnt, 2);
        check("refresh addr", refreshAddr, 14'h0002);
        cmd(3'h1, 1'b0, 1'b0, 2'h0, 12'h000);
        check("self refresh", selfRefresh, 1'b1);
        cmd(3'h7, 1'b0, 1'b1, 2'h0, 12'h000);
        check("self exit", selfRefresh, 1'b0);
        summarize();
    end
endmodule : tb_top
